/* File: rtl/pfcs_regs.svh */
// Offsets, field positions, command codes and timing counts
`ifndef PFCS_REGS_SVH
`define PFCS_REGS_SVH

// ----------------------------------------
// Clock and flash bus timing
// ----------------------------------------
`define PFCS_CLK_MHZ 250
`define PFCS_CYC_MIN(ns) ((((ns) * `PFCS_CLK_MHZ) + 999) / 1000)
`define PFCS_T_SETUP_NS 10
`define PFCS_T_WP_NS 40
`define PFCS_T_WPH_NS 20
`define PFCS_T_ACC_NS 70
`define PFCS_SYNC_LAT 4
`define PFCS_PWR_DLY_MS 10
`define PFCS_PWR_DLY_CYC (`PFCS_PWR_DLY_MS * `PFCS_CLK_MHZ * 1000)

// ----------------------------------------
// Command addresses and data codes
// ----------------------------------------
`define PFCS_A_UNLK1 12'h555
`define PFCS_A_UNLK2 12'hAAA
`define PFCS_A_QUERY 12'h055
`define PFCS_A_PLOCK 12'h080
`define PFCS_D_UNLK1 8'hAA
`define PFCS_D_UNLK2 8'h55
`define PFCS_D_PROG 8'hA0
`define PFCS_D_DUAL 8'hE0
`define PFCS_D_ERPRE 8'h80
`define PFCS_D_CHIP 8'h10
`define PFCS_D_SECT 8'h30
`define PFCS_D_LOCKDN 8'h60
`define PFCS_D_SUSP 8'hB0
`define PFCS_D_RESUME 8'h30
`define PFCS_D_IDENT 8'h90
`define PFCS_D_IDEXIT 8'hF0
`define PFCS_D_PROT 8'hC0
`define PFCS_D_CFG 8'hD0
`define PFCS_D_QUERY 8'h98

// ----------------------------------------
// Status bits on the flash data bus
// ----------------------------------------
`define PFCS_DQ_TOGGLE 6
`define PFCS_DQ_TIMEOUT 5
`define PFCS_DQ_SUPLOW 3

// ----------------------------------------
// Software register map
// ----------------------------------------
`define PFCS_REG_CMD 8'h00
`define PFCS_REG_ADDR0 8'h04
`define PFCS_REG_DATA0 8'h08
`define PFCS_REG_ADDR1 8'h0C
`define PFCS_REG_DATA1 8'h10
`define PFCS_REG_STATUS 8'h14
`define PFCS_REG_RDATA 8'h18
`define PFCS_ST_BUSY 0
`define PFCS_ST_ERR 1
`define PFCS_ST_PWROK 2
`define PFCS_ST_RDY 3
`define PFCS_ST_FAIL 4
`define PFCS_ST_SUPLOW 5
`define PFCS_ST_MODE 6
`define PFCS_ST_CFG 8
`define PFCS_CFG_RST 2'h0

`endif

/* File: rtl/pfcs_pkg.sv */
// Types shared by the flash command controller
package pfcs_pkg;
  typedef enum logic [4:0] {
    OP_READ = 5'h00, OP_WORD_PROG = 5'h01, OP_DUAL_PROG = 5'h02,
    OP_CHIP_ERASE = 5'h03, OP_SECT_ERASE = 5'h04, OP_LOCKDOWN = 5'h05,
    OP_SP_ENTER = 5'h06, OP_SP_WRITE = 5'h07, OP_SUSPEND = 5'h08,
    OP_RESUME = 5'h09, OP_ID_ENTER = 5'h0A, OP_ID_EXIT3 = 5'h0B,
    OP_ID_EXIT1 = 5'h0C, OP_QUERY = 5'h0D, OP_PROT_PROG = 5'h0E,
    OP_PROT_LOCK = 5'h0F, OP_SET_CFG = 5'h10, OP_POLL = 5'h11
  } pfcs_op_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_ID = 2'b01, MODE_QUERY = 2'b10, MODE_SP = 2'b11
  } pfcs_mode_t;

  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] dq_drive;
    logic dq_en;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } pfcs_pins_t;

  typedef struct packed {
    logic wr;
    logic [20:0] addr;
    logic [15:0] data;
  } pfcs_req_t;
endpackage

/* File: rtl/pfcs_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pfcs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pfcs_sync_st_t;

  pfcs_sync_st_t r;
  pfcs_sync_st_t n;

  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Only a value held by two stages counts
    if (r.s2 == r.s3) begin
      n.q = r.s3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.q;
endmodule // pfcs_sync

/* File: rtl/pfcs_bus_engine.sv */
// One flash bus cycle: write strobe or read access
`timescale 1ns/1ps
`include "pfcs_regs.svh"
module pfcs_bus_engine (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input pfcs_pkg::pfcs_req_t req,
  input wire logic [15:0] dq_sync,
  output pfcs_pkg::pfcs_pins_t pins,
  output logic [15:0] rdata,
  output logic done
);
  import pfcs_pkg::*;

  localparam logic [7:0] T_SETUP = 8'(`PFCS_CYC_MIN(`PFCS_T_SETUP_NS));
  localparam logic [7:0] T_WP = 8'(`PFCS_CYC_MIN(`PFCS_T_WP_NS));
  localparam logic [7:0] T_WPH = 8'(`PFCS_CYC_MIN(`PFCS_T_WPH_NS));
  localparam logic [7:0] T_RD = 8'(`PFCS_CYC_MIN(`PFCS_T_ACC_NS) + `PFCS_SYNC_LAT);

  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_SETUP = 3'b001, E_STROBE = 3'b010,
    E_HOLD = 3'b011, E_READ = 3'b100
  } pfcs_eph_t;

  typedef struct packed {
    pfcs_eph_t ph;
    logic [7:0] cnt;
    pfcs_pins_t pins;
    logic [15:0] rdata;
    logic done;
  } pfcs_eng_st_t;

  localparam pfcs_eng_st_t RST = '{ph: E_IDLE, cnt: 8'h00,
    pins: '{21'h000000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b1}, rdata: 16'h0000, done: 1'b0};

  pfcs_eng_st_t r;
  pfcs_eng_st_t n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.cnt = r.cnt - 8'h01;
    case (r.ph)
      E_IDLE: begin
        n.cnt = r.cnt;
        if (start) begin
          n.pins.addr = req.addr;
          n.pins.ce_n = 1'b0;
          if (req.wr) begin
            // output drive held off on writes
            n.pins.oe_n = 1'b1;
            n.pins.dq_drive = req.data;
            n.pins.dq_en = 1'b1;
            n.cnt = T_SETUP - 8'h01;
            n.ph = E_SETUP;
          end else begin
            n.pins.oe_n = 1'b0;
            n.cnt = T_RD - 8'h01;
            n.ph = E_READ;
          end
        end
      end
      E_SETUP: begin
        if (r.cnt == 8'h00) begin
          n.pins.we_n = 1'b0;
          n.cnt = T_WP - 8'h01;
          n.ph = E_STROBE;
        end
      end
      E_STROBE: begin
        // Data is latched by the rising write strobe
        if (r.cnt == 8'h00) begin
          n.pins.we_n = 1'b1;
          n.cnt = T_WPH - 8'h01;
          n.ph = E_HOLD;
        end
      end
      E_HOLD: begin
        if (r.cnt == 8'h00) begin
          n.pins.ce_n = 1'b1;
          n.pins.dq_en = 1'b0;
          n.done = 1'b1;
          n.ph = E_IDLE;
        end
      end
      E_READ: begin
        if (r.cnt == 8'h00) begin
          n.rdata = dq_sync;
          n.pins.ce_n = 1'b1;
          n.pins.oe_n = 1'b1;
          n.done = 1'b1;
          n.ph = E_IDLE;
        end
      end
      default: begin
        n = RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign pins = r.pins;
  assign rdata = r.rdata;
  assign done = r.done;
endmodule // pfcs_bus_engine

/* File: rtl/pfcs_ctrl.sv */
// Host-side command sequencer and status poller for a parallel NOR flash
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pfcs_regs.svh"

module pfcs_ctrl #(
  parameter int unsigned PWR_DLY_CYC = `PFCS_PWR_DLY_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output pfcs_pkg::pfcs_pins_t flash_bus,
  input wire logic [15:0] flash_dq,
  input wire logic flash_rdy,
  output logic flash_reset_n,
  output logic busy
);
  import pfcs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ISSUE = 3'b001, S_WAIT = 3'b010,
    S_POLL = 3'b011, S_PWAIT = 3'b100
  } pfcs_st_t;

  typedef struct packed {
    pfcs_st_t st;
    pfcs_op_t op;
    logic [2:0] idx;
    logic [20:0] a0;
    logic [15:0] d0;
    logic [20:0] a1;
    logic [15:0] d1;
    pfcs_mode_t mode;
    logic [1:0] cfg;
    logic [21:0] pwr_cnt;
    logic pwr_ok;
    logic err;
    logic fail;
    logic sup_low;
    logic busy;
    logic start;
    pfcs_req_t req;
    logic [15:0] prev;
    logic have_prev;
    logic recheck;
    logic [15:0] fdata;
    logic [31:0] rdata;
    logic rst_n;
  } pfcs_ctrl_st_t;

  localparam pfcs_ctrl_st_t RST = '{st: S_IDLE, op: OP_READ, idx: 3'h0,
    a0: 21'h000000, d0: 16'h0000, a1: 21'h000000, d1: 16'h0000,
    mode: MODE_NORMAL, cfg: `PFCS_CFG_RST, pwr_cnt: 22'h000000,
    pwr_ok: 1'b0, err: 1'b0, fail: 1'b0, sup_low: 1'b0, busy: 1'b0,
    start: 1'b0, req: '{1'b0, 21'h000000, 16'h0000}, prev: 16'h0000,
    have_prev: 1'b0, recheck: 1'b0, fdata: 16'h0000, rdata: 32'h00000000,
    rst_n: 1'b0};

  pfcs_ctrl_st_t r;
  pfcs_ctrl_st_t n;
  logic [15:0] dq_s;
  logic rdy_s;
  logic eng_done;
  logic [15:0] eng_rdata;

  // ----------------------------------------
  // Sequence decoding
  // ----------------------------------------
  function automatic logic [2:0] seq_len(pfcs_op_t op);
    case (op)
      OP_ID_ENTER, OP_ID_EXIT3: seq_len = 3'h3;
      OP_WORD_PROG, OP_PROT_PROG, OP_PROT_LOCK, OP_SET_CFG: seq_len = 3'h4;
      OP_DUAL_PROG: seq_len = 3'h5;
      OP_CHIP_ERASE, OP_SECT_ERASE, OP_LOCKDOWN, OP_SP_ENTER: seq_len = 3'h6;
      default: seq_len = 3'h1;
    endcase
  endfunction

  // Command cycles carry only address 11:0 and data 7:0
  function automatic pfcs_req_t cmd_cyc(logic [11:0] a, logic [7:0] d);
    cmd_cyc = '{1'b1, {9'h000, a}, {8'h00, d}};
  endfunction

  function automatic pfcs_req_t seq_step(pfcs_op_t op, logic [2:0] i,
      logic [20:0] a0, logic [15:0] d0, logic [20:0] a1, logic [15:0] d1);
    logic [7:0] c3;
    logic six;
    six = (seq_len(op) == 3'h6);
    case (op)
      OP_WORD_PROG: c3 = `PFCS_D_PROG;
      OP_DUAL_PROG: c3 = `PFCS_D_DUAL;
      OP_ID_ENTER: c3 = `PFCS_D_IDENT;
      OP_ID_EXIT3: c3 = `PFCS_D_IDEXIT;
      OP_PROT_PROG, OP_PROT_LOCK: c3 = `PFCS_D_PROT;
      OP_SET_CFG: c3 = `PFCS_D_CFG;
      default: c3 = `PFCS_D_ERPRE;
    endcase
    seq_step = cmd_cyc(`PFCS_A_UNLK1, `PFCS_D_UNLK1);
    if (seq_len(op) == 3'h1) begin
      case (op)
        OP_READ: seq_step = '{1'b0, a0, 16'h0000};
        // Single write programs in single-pulse mode
        OP_SP_WRITE: seq_step = '{1'b1, a0, d0};
        // Suspend and resume at any address
        OP_SUSPEND: seq_step = '{1'b1, a0, {8'h00, `PFCS_D_SUSP}};
        OP_RESUME: seq_step = '{1'b1, a0, {8'h00, `PFCS_D_RESUME}};
        OP_ID_EXIT1: seq_step = '{1'b1, a0, {8'h00, `PFCS_D_IDEXIT}};
        default: seq_step = cmd_cyc(`PFCS_A_QUERY, `PFCS_D_QUERY);
      endcase
    end else begin
      case (i)
        3'h0: seq_step = cmd_cyc(`PFCS_A_UNLK1, `PFCS_D_UNLK1);
        3'h1: seq_step = cmd_cyc(`PFCS_A_UNLK2, `PFCS_D_UNLK2);
        // Prefix third write picks the command, or only its group: the erase ops share 80h, the protection ops C0h
        3'h2: seq_step = cmd_cyc(`PFCS_A_UNLK1, c3);
        3'h3: begin
          if (six) begin
            seq_step = cmd_cyc(`PFCS_A_UNLK1, `PFCS_D_UNLK1);
          end else if (op == OP_PROT_LOCK) begin
            // Lock write keeps low data nibble zero
            seq_step = cmd_cyc(`PFCS_A_PLOCK, {d0[7:4], 4'h0});
          end else if (op == OP_SET_CFG) begin
            seq_step = '{1'b1, a0, {15'h0000, d0[0]}};
          end else begin
            // Target word, also protection and dual first word
            seq_step = '{1'b1, a0, d0};
          end
        end
        3'h4: begin
          if (six) begin
            seq_step = cmd_cyc(`PFCS_A_UNLK2, `PFCS_D_UNLK2);
          end else begin
            seq_step = '{1'b1, a1, d1};
          end
        end
        default: begin
          case (op)
            OP_CHIP_ERASE: seq_step = cmd_cyc(`PFCS_A_UNLK1, `PFCS_D_CHIP);
            OP_SECT_ERASE: seq_step = '{1'b1, a0, {8'h00, `PFCS_D_SECT}};
            OP_LOCKDOWN: seq_step = '{1'b1, a0, {8'h00, `PFCS_D_LOCKDN}};
            default: seq_step = cmd_cyc(`PFCS_A_UNLK1, `PFCS_D_PROG);
          endcase
        end
      endcase
    end
  endfunction

  // Commands the flash would misread in its present mode are not sent
  function automatic logic op_refused(logic [4:0] code, pfcs_mode_t m, logic pwr_ok);
    logic rd;
    logic prog;
    rd = (code == OP_READ) || (code == OP_POLL);
    prog = code inside {OP_WORD_PROG, OP_DUAL_PROG, OP_CHIP_ERASE, OP_SECT_ERASE,
      OP_LOCKDOWN, OP_SP_ENTER, OP_SP_WRITE, OP_PROT_PROG, OP_PROT_LOCK};
    case (m)
      MODE_NORMAL: op_refused = (code == OP_SP_WRITE);
      // Query entry also from identification mode
      MODE_ID: op_refused = !(rd || code inside {OP_ID_EXIT3, OP_ID_EXIT1, OP_QUERY});
      // Query mode only left by identification exit
      MODE_QUERY: op_refused = !(rd || code inside {OP_ID_EXIT3, OP_ID_EXIT1});
      // Other writes would be programmed as data
      default: op_refused = !(rd || code == OP_SP_WRITE);
    endcase
    // Program and erase held off until power-on delay ends
    if ((prog && !pwr_ok) || code > OP_POLL) begin
      op_refused = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    n = r;
    n.start = 1'b0;
    n.rst_n = 1'b1;
    n.rdata = 32'h00000000;
    if (!r.pwr_ok) begin
      n.pwr_cnt = r.pwr_cnt + 22'h000001;
      if (r.pwr_cnt >= 22'(PWR_DLY_CYC - 1)) begin
        n.pwr_ok = 1'b1;
      end
    end
    if (sw_rd) begin
      case (sw_addr)
        `PFCS_REG_CMD: n.rdata = {27'h0000000, r.op};
        `PFCS_REG_ADDR0: n.rdata = {11'h000, r.a0};
        `PFCS_REG_DATA0: n.rdata = {16'h0000, r.d0};
        `PFCS_REG_ADDR1: n.rdata = {11'h000, r.a1};
        `PFCS_REG_DATA1: n.rdata = {16'h0000, r.d1};
        `PFCS_REG_STATUS: begin
          n.rdata[`PFCS_ST_BUSY] = r.busy;
          n.rdata[`PFCS_ST_ERR] = r.err;
          n.rdata[`PFCS_ST_PWROK] = r.pwr_ok;
          n.rdata[`PFCS_ST_RDY] = rdy_s;
          n.rdata[`PFCS_ST_FAIL] = r.fail;
          n.rdata[`PFCS_ST_SUPLOW] = r.sup_low;
          n.rdata[`PFCS_ST_MODE +: 2] = r.mode;
          n.rdata[`PFCS_ST_CFG +: 2] = r.cfg;
        end
        `PFCS_REG_RDATA: n.rdata = {16'h0000, r.fdata};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (sw_wr && !r.busy) begin
      case (sw_addr)
        `PFCS_REG_ADDR0: n.a0 = sw_wdata[20:0];
        `PFCS_REG_DATA0: n.d0 = sw_wdata[15:0];
        `PFCS_REG_ADDR1: n.a1 = sw_wdata[20:0];
        `PFCS_REG_DATA1: n.d1 = sw_wdata[15:0];
        default: n.err = r.err;
      endcase
    end
    case (r.st)
      S_IDLE: begin
        if (sw_wr && sw_addr == `PFCS_REG_CMD) begin
          if (op_refused(sw_wdata[4:0], r.mode, r.pwr_ok)) begin
            n.err = 1'b1;
          end else begin
            n.op = pfcs_op_t'(sw_wdata[4:0]);
            n.idx = 3'h0;
            n.busy = 1'b1;
            n.err = 1'b0;
            n.st = S_ISSUE;
            if (sw_wdata[4:0] == OP_POLL) begin
              n.fail = 1'b0;
              n.sup_low = 1'b0;
              n.have_prev = 1'b0;
              n.recheck = 1'b0;
              n.st = S_POLL;
            end
          end
        end
      end
      S_ISSUE: begin
        // Whole sequence goes out unbroken, never mixed with other cycles
        n.req = seq_step(r.op, r.idx, r.a0, r.d0, r.a1, r.d1);
        n.start = 1'b1;
        n.st = S_WAIT;
      end
      S_WAIT: begin
        if (eng_done) begin
          if (r.op == OP_READ) begin
            n.fdata = eng_rdata;
          end
          if (r.idx == seq_len(r.op) - 3'h1) begin
            n.busy = 1'b0;
            n.st = S_IDLE;
            case (r.op)
              OP_ID_ENTER: n.mode = MODE_ID;
              OP_QUERY: n.mode = MODE_QUERY;
              // Identification exit also ends query mode
              OP_ID_EXIT1, OP_ID_EXIT3: n.mode = MODE_NORMAL;
              OP_SP_ENTER: n.mode = MODE_SP;
              // Record the polling convention now in force
              OP_SET_CFG: n.cfg = {1'b0, r.d0[0]};
              default: n.mode = r.mode;
            endcase
          end else begin
            n.idx = r.idx + 3'h1;
            n.st = S_ISSUE;
          end
        end
      end
      S_POLL: begin
        n.req = '{1'b0, r.a0, 16'h0000};
        n.start = 1'b1;
        n.st = S_PWAIT;
      end
      S_PWAIT: begin
        if (eng_done) begin
          n.fdata = eng_rdata;
          n.prev = eng_rdata;
          n.have_prev = 1'b1;
          n.st = S_POLL;
          if (r.have_prev) begin
            // Toggle bit steady means the operation ended
            if (eng_rdata[`PFCS_DQ_TOGGLE] == r.prev[`PFCS_DQ_TOGGLE]) begin
              n.busy = 1'b0;
              n.st = S_IDLE;
            end else if (r.recheck) begin
              n.fail = 1'b1;
              // Supply-low taken only from a failing status read
              n.sup_low = eng_rdata[`PFCS_DQ_SUPLOW];
              n.busy = 1'b0;
              n.st = S_IDLE;
            end else if (eng_rdata[`PFCS_DQ_TIMEOUT] || eng_rdata[`PFCS_DQ_SUPLOW]) begin
              // Toggle may stop as the flag rises; read once more
              n.recheck = 1'b1;
            end
          end
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and bus cycle engine
  // ----------------------------------------
  pfcs_sync #(.W(16)) u_dq_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(flash_dq),
    .sync_out(dq_s)
  );

  pfcs_sync #(.W(1)) u_rdy_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(flash_rdy),
    .sync_out(rdy_s)
  );

  pfcs_bus_engine u_engine (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(r.start),
    .req(r.req),
    .dq_sync(dq_s),
    .pins(flash_bus),
    .rdata(eng_rdata),
    .done(eng_done)
  );

  assign sw_rdata = r.rdata;
  assign flash_reset_n = r.rst_n;
  assign busy = r.busy;
endmodule // pfcs_ctrl

/* File: sim/pfcs_flash_model.sv */
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ps
module pfcs_flash_model #(
  parameter int BUSY_NS = 600
) (
  input pfcs_pkg::pfcs_pins_t pins,
  output logic [15:0] dq,
  output logic rdy
);
  import pfcs_pkg::*;
  localparam logic [19:0] U1 = 20'h555AA;
  localparam logic [19:0] U2 = 20'hAAA55;
  logic [19:0] h [6] = '{default: 20'h0};
  logic [1:0] md = 2'd0;
  logic cfg = 1'b0;
  logic bz = 1'b0, er = 1'b0, tg = 1'b0, sus = 1'b0;
  logic [20:0] pa = 21'h0;
  logic [15:0] pd = 16'hFFFF, rv;
  int ners = 0;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.oe_n && !bz) begin
      for (int i = 5; i > 0; i--) h[i] = h[i-1];
      h[0] = {pins.addr[11:0], pins.dq_drive[7:0]};
      if (h[2] == U1 && h[1] == U2 && h[0] == 20'h55590) md = 2'd1;
      if (h[0][7:0] == 8'hF0) md = 2'd0;
      if (h[0][15:0] == 16'h5598) md = 2'd2;
      if (h[3] == U1 && h[2] == U2 && h[1] == 20'h555A0) begin
        pa = pins.addr;
        pd = pins.dq_drive;
        er = 1'b0;
        bz = 1'b1;
      end
      if (h[3] == U1 && h[2] == U2 && h[1] == 20'h555D0) cfg = h[0][0];
      if (h[5] == U1 && h[4] == U2 && h[3] == 20'h55580 && h[2] == U1 && h[1] == U2
          && (h[0] == 20'h55510 || h[0][7:0] == 8'h30)) begin
        pa = pins.addr;
        pd = 16'hFFFF;
        er = 1'b1;
        bz = 1'b1;
        ners++;
      end
    end
  end
  // suspend and resume act only on a running operation
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.oe_n && bz && pins.dq_drive[7:0] == 8'hB0) sus = 1'b1;
    else if (!pins.ce_n && pins.oe_n && sus && pins.dq_drive[7:0] == 8'h30) sus = 1'b0;
  end
  // Suspension freezes the internal timer
  always @(posedge bz) begin
    for (int t = 0; t < BUSY_NS; t += sus ? 0 : 1) #1;
    bz = 1'b0;
  end
  always @(posedge pins.oe_n) if (bz) tg = ~tg;
  always_comb begin
    if (bz && !sus) rv = {8'h00, !cfg && !er && !pd[7], tg, 3'b000, er ? tg : 1'b1, 2'b00};
    // suspended sector: fixed status, erase toggle running
    else if (bz && pins.addr[20:12] == pa[20:12])
      rv = {8'h00, er || cfg || !pd[7], 1'b1, 3'b000, tg, 2'b00};
    else if (md != 2'd0) rv = {14'h0, md};
    else rv = (pins.addr == pa) ? pd : 16'hFFFF;
  end
  // ready low through internal cycles, high when suspended
  assign rdy = !bz || sus;
  // Released bus shows the inverse, never a stale value
  assign dq = (!pins.ce_n && !pins.oe_n) ? rv : ~rv;
endmodule // pfcs_flash_model

/* File: sim/pfcs_ctrl_assertions.sv */
// Timing checks on the flash controller ports
`timescale 1ns/1ps
module pfcs_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input pfcs_pkg::pfcs_pins_t flash_bus,
  input wire logic flash_reset_n,
  input wire logic busy
);
  import pfcs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_rd_idle: assert property (!sw_rd |=> sw_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_we_guard: assert property (
    !flash_bus.we_n |-> !flash_bus.ce_n && flash_bus.oe_n && flash_bus.dq_en)
    else $error("write strobe without select");
  chk_we_setup: assert property (
    $fell(flash_bus.ce_n) && flash_bus.dq_en |-> flash_bus.we_n[*3] ##1 !flash_bus.we_n)
    else $error("write setup wrong");
  chk_we_width: assert property ($fell(flash_bus.we_n) |-> ##10 $rose(flash_bus.we_n))
    else $error("write strobe width wrong");
  chk_we_hold: assert property (
    !flash_bus.we_n |-> $stable(flash_bus.addr) && $stable(flash_bus.dq_drive))
    else $error("address or data moved");
  chk_oe_width: assert property ($fell(flash_bus.oe_n) |-> ##22 $rose(flash_bus.oe_n))
    else $error("read strobe width wrong");
  chk_rd_excl: assert property (
    !flash_bus.oe_n |-> flash_bus.we_n && !flash_bus.dq_en && !flash_bus.ce_n)
    else $error("read overlaps drive");
  chk_busy_start: assert property ($rose(busy) |-> ##2 !flash_bus.ce_n)
    else $error("bus cycle late");
  chk_rst_pin: assert property (disable iff (1'b0) !nrst |=> !flash_reset_n)
    else $error("flash reset not held");
endmodule // pfcs_ctrl_assertions

/* File: sim/pfcs_ctrl_tb_top.sv */
// Testbench for the flash command controller
`timescale 1ns/1ps
module pfcs_ctrl_tb_top;
  import pfcs_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, busy, rst_n, flash_rdy;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, v, w;
  logic [15:0] flash_dq;
  logic [6:0] mt [5] = '{7'h2A, 7'h4D, 7'h0B, 7'h2A, 7'h0C};
  pfcs_pins_t flash_bus;
  int n_errors = 0, compares = 0;
  always #2 clk_sys = ~clk_sys;
  pfcs_ctrl #(.PWR_DLY_CYC(20)) i_pfcs_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .flash_bus(flash_bus), .flash_dq(flash_dq),
    .flash_rdy(flash_rdy), .flash_reset_n(rst_n), .busy(busy));
  pfcs_flash_model i_pfcs_flash_model (.pins(flash_bus), .dq(flash_dq), .rdy(flash_rdy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  // Bounded wait; a hang ends the run
  task automatic cmd(input logic [4:0] op);
    wr(8'h00, {27'h0, op});
    @(posedge clk_sys);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk_sys);
    if (busy !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h14);
    chk(v & 32'h3F7, 32'h0);
    cmd(5'h01);
    rd(8'h14);
    chk(v & 32'h7, 32'h2);
    repeat (20) @(posedge clk_sys);
    rd(8'h14);
    chk(v & 32'h7, 32'h6);
    $display("test power done");
    wr(8'h04, 32'h12345);
    wr(8'h08, 32'h5A3C);
    cmd(5'h01);
    rd(8'h14);
    chk(v & 32'hB, 32'h0);
    chk({11'h0, i_pfcs_flash_model.pa}, 32'h12345);
    chk({16'h0, i_pfcs_flash_model.pd}, 32'h5A3C);
    cmd(5'h08);
    cmd(5'h00);
    rd(8'h18);
    w = v;
    chk(w & 32'hFFFB, 32'hC0);
    cmd(5'h00);
    rd(8'h18);
    chk(v ^ w, 32'h4);
    wr(8'h04, 32'h0);
    cmd(5'h00);
    rd(8'h18);
    chk(v, 32'hFFFF);
    rd(8'h14);
    chk(v & 32'h9, 32'h8);
    wr(8'h04, 32'h12345);
    cmd(5'h09);
    cmd(5'h11);
    rd(8'h14);
    chk(v & 32'h3B, 32'h8);
    cmd(5'h00);
    rd(8'h18);
    chk(v, 32'h5A3C);
    $display("test program done");
    foreach (mt[i]) begin
      cmd(mt[i][4:0]);
      rd(8'h14);
      chk(v & 32'hC0, {24'h0, mt[i][6:5], 6'h0});
    end
    cmd(5'h0D);
    cmd(5'h00);
    rd(8'h18);
    chk(v, 32'h2);
    cmd(5'h01);
    rd(8'h14);
    chk(v & 32'hC2, 32'h82);
    cmd(5'h0C);
    cmd(5'h00);
    rd(8'h18);
    chk(v, 32'h5A3C);
    $display("test modes done");
    for (int c = 1; c >= 0; c--) begin
      wr(8'h08, 32'(c));
      cmd(5'h10);
      rd(8'h14);
      chk(v & 32'h300, 32'(c << 8));
      chk({31'h0, i_pfcs_flash_model.cfg}, 32'(c));
    end
    cmd(5'h04);
    cmd(5'h11);
    cmd(5'h03);
    cmd(5'h11);
    chk(32'(i_pfcs_flash_model.ners), 32'd2);
    cmd(5'h00);
    rd(8'h18);
    chk(v, 32'hFFFF);
    rd(8'h1C);
    chk(v, 32'h0);
    $display("test erase done");
    give_verdict();
  end
endmodule // pfcs_ctrl_tb_top
bind pfcs_ctrl pfcs_ctrl_assertions i_pfcs_ctrl_assertions (.clk_sys(clk_sys), .nrst(nrst),
  .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_bus(flash_bus),
  .flash_reset_n(flash_reset_n), .busy(busy));
